// ---- inc/tmr_pkg.sv ----
// register map, field layout, reset values and types of the 16-bit
// timer / event / window counter.
// assumes APB, 32-bit data, 8-bit byte address.
package tmr_pkg;

	// ==========================================================
	// register indices; byte address is four times the index
	// ==========================================================
	localparam int unsigned  ADDR_W      = 8;
	localparam logic [5:0]   IDX_CTRL    = 6'h23; // counter_control_reg
	localparam logic [5:0]   IDX_CMP_LO  = 6'h24; // compare_low_byte
	localparam logic [5:0]   IDX_CMP_HI  = 6'h25; // compare_high_byte
	localparam logic [5:0]   IDX_COUNT   = 6'h26; // live count readout
	localparam logic [5:0]   IDX_STATUS  = 6'h27; // block status

	// ==========================================================
	// field positions
	// ==========================================================
	localparam int unsigned  CTRL_MODE_POS   = 0;  // mode_select_bit
	localparam int unsigned  CTRL_CK_LSB     = 2;  // source_clock_select
	localparam int unsigned  CTRL_RUN_POS    = 5;  // run_control_bit
	localparam int unsigned  STAT_RUN_POS    = 0;
	localparam int unsigned  STAT_PEND_POS   = 1;
	localparam int unsigned  STAT_PIN_POS    = 2;
	localparam int unsigned  STAT_MASK_POS   = 3;
	localparam int unsigned  MASK_LOW_BITS   = 11; // ignored during warm-up

	// ==========================================================
	// values after reset
	// ==========================================================
	localparam logic [15:0]  CMP_RESET   = 16'hFFFF;
	localparam logic [15:0]  COUNT_RESET = 16'h0000;
	localparam logic [7:0]   BYTE_RESET  = 8'h00;

	// ==========================================================
	// types
	// ==========================================================
	typedef enum logic [2:0] {
		CK_SLOW_DIV  = 3'b000,
		CK_MID_DIV   = 3'b001,
		CK_FAST_DIV  = 3'b010,
		CK_HF_DIV8   = 3'b011,
		CK_HIGH_FREQ = 3'b100, // high_freq_osc, warm-up use
		CK_LOW_FREQ  = 3'b101, // low_freq_osc
		CK_RESERVED  = 3'b110,
		CK_PIN       = 3'b111  // counter_input_pin
	} clk_sel_e;

	typedef enum logic [1:0] {
		MODE_IDLE   = 2'b00,
		MODE_TIMER  = 2'b01,
		MODE_EVENT  = 2'b10,
		MODE_WINDOW = 2'b11
	} count_mode_e;

	typedef struct packed {
		logic      run;
		clk_sel_e  clk_sel;
		logic      window;
	} ctrl_s;

	localparam ctrl_s CTRL_RESET = '{run: 1'b0, clk_sel: CK_SLOW_DIV, window: 1'b0};

	typedef struct packed {
		logic  level;
		logic  rise;
		logic  fall;
	} pin_ev_s;

endpackage : tmr_pkg

// ---- design/pin_sync.sv ----
// three-flop synchroniser with agreement filter and edge pulses.
// assumes an async input held two cycles per level.
`timescale 1ns/10ps
`default_nettype none

module pin_sync (
	// clock and reset
	input  wire logic      pclk,
	input  wire logic      presetn,
	// raw pin and filtered result
	input  wire logic      pin_raw,
	output tmr_pkg::pin_ev_s ev
);

	logic  s1;
	logic  s2;
	logic  s3;
	logic  level;

	// ==========================================================
	// synchroniser chain; s1 feeds only s2
	// ==========================================================
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= pin_raw;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// level moves only when second and third stages agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level <= 1'b0;
		end else if (s2 == s3) begin
			level <= s3;
		end
	end

	// edges are one-cycle pulses from the filtered level
	always_comb begin
		ev.level = level;
		ev.rise  = (s2 == s3) && s3 && !level;
		ev.fall  = (s2 == s3) && !s3 && level;
	end

endmodule : pin_sync

`default_nettype wire

// ---- design/compare_unit.sv ----
// compare register, low-then-high pairing and match check.
// assumes one-cycle write strobes from the bus decoder.
`timescale 1ns/10ps
`default_nettype none

module compare_unit (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// byte writes
	input  wire logic         wr_lo,
	input  wire logic         wr_hi,
	input  wire logic [7:0]   wbyte,
	// comparison
	input  wire logic [15:0]  count_val,
	input  wire logic         mask_low,
	output logic              hit,
	// state
	output logic [15:0]       compare_value_reg,
	output logic              pending
);

	logic [7:0]  staged_lo;

	// ==========================================================
	// low byte is staged; only a following high write commits
	// ==========================================================
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			staged_lo         <= tmr_pkg::BYTE_RESET;
			pending           <= 1'b0;
			compare_value_reg <= tmr_pkg::CMP_RESET;
		end else if (wr_lo) begin
			staged_lo <= wbyte;
			pending   <= 1'b1;
		end else if (wr_hi && pending) begin
			compare_value_reg <= {wbyte, staged_lo};
			pending           <= 1'b0;
		end
	end

	// warm-up compares the upper five bits only
	always_comb begin
		if (mask_low) begin
			hit = count_val[15:tmr_pkg::MASK_LOW_BITS] ==
			      compare_value_reg[15:tmr_pkg::MASK_LOW_BITS];
		end else begin
			hit = count_val == compare_value_reg;
		end
	end

endmodule : compare_unit

`default_nettype wire

// ---- design/event_window_counter.sv ----
// 16-bit up-counter with timer, event and window modes behind APB.
// assumes an external prescaler supplies one-cycle source ticks and the
// power-mode controller supplies low-speed and stop-entry indications.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - three modes: timer, event, window counting
// - timer mode can time oscillator warm-up
// - timer counts ticks, match interrupts and clears
// - warm-up match uses upper five bits only
// - event mode counts pin rising edges
// - event match checked on pin falling edge
// - window counts ticks while pin is high
// - run bit zero halts and clears counter
// - mode bit: zero timer/event, one window
// - compare updates only on low-then-high write
// - stop mode entry clears the run bit
module event_window_counter #(
	parameter int unsigned  COUNT_W = 16
) (
	// clock and reset
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	// apb slave
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [tmr_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	// source ticks from the prescaler, one per select code 000..101
	input  wire logic [5:0]                   src_tick,
	// power-mode indications
	input  wire logic                         low_speed_mode_two,
	input  wire logic                         stop_mode_entry,
	// external pin and event output
	input  wire logic                         counter_input_pin,
	output logic                              match_interrupt
);

	// ==========================================================
	// declarations
	// ==========================================================
	tmr_pkg::ctrl_s        counter_control_reg;
	tmr_pkg::count_mode_e  mode;
	tmr_pkg::pin_ev_s      pin;
	logic [COUNT_W-1:0]    count;
	logic [COUNT_W-1:0]    next_count;
	logic [15:0]           compare_value_reg;
	logic                  cmp_pending;
	logic                  hit_now;
	logic                  hit_next;
	logic                  warmup_mask;
	logic                  tick;
	logic                  next_match;
	logic                  setup_phase;
	logic                  access_phase;
	logic                  wr_ctrl;
	logic                  wr_lo;
	logic                  wr_hi;
	logic                  mapped;
	logic [31:0]           next_rdata;
	logic [COUNT_W-1:0]    count_plus;

	// ==========================================================
	// address decoding
	// ==========================================================
	// byte address of a register index
	function automatic logic addr_hit(input logic [tmr_pkg::ADDR_W-1:0] a,
	                                  input logic [5:0] idx);
		addr_hit = (a == {idx, 2'b00});
	endfunction : addr_hit

	// any mapped register
	function automatic logic addr_mapped(input logic [tmr_pkg::ADDR_W-1:0] a);
		addr_mapped = addr_hit(a, tmr_pkg::IDX_CTRL) ||
		              addr_hit(a, tmr_pkg::IDX_CMP_LO) ||
		              addr_hit(a, tmr_pkg::IDX_CMP_HI) ||
		              addr_hit(a, tmr_pkg::IDX_COUNT) ||
		              addr_hit(a, tmr_pkg::IDX_STATUS);
	endfunction : addr_mapped

	// phases of an apb transfer; zero wait states
	always_comb begin
		setup_phase  = psel && !penable;
		access_phase = psel && penable;
		mapped       = addr_mapped(paddr);
		wr_ctrl      = access_phase && pwrite && addr_hit(paddr, tmr_pkg::IDX_CTRL);
		wr_lo        = access_phase && pwrite && addr_hit(paddr, tmr_pkg::IDX_CMP_LO);
		wr_hi        = access_phase && pwrite && addr_hit(paddr, tmr_pkg::IDX_CMP_HI);
	end

	// no wait states
	assign pready = 1'b1;

	// unmapped addresses answer with an error, writes are dropped
	assign pslverr = access_phase && !mapped;

	// ==========================================================
	// control register
	// ==========================================================
	// stop entry beats a software write in the same cycle, so the
	// counter can never run on into stop mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_control_reg <= tmr_pkg::CTRL_RESET;
		end else if (stop_mode_entry) begin
			counter_control_reg.run <= 1'b0;
		end else if (wr_ctrl) begin
			counter_control_reg.run     <= pwdata[tmr_pkg::CTRL_RUN_POS];
			counter_control_reg.clk_sel <=
				tmr_pkg::clk_sel_e'(pwdata[tmr_pkg::CTRL_CK_LSB +: 3]);
			counter_control_reg.window  <= pwdata[tmr_pkg::CTRL_MODE_POS];
		end
	end

	// ==========================================================
	// mode selection
	// ==========================================================
	// pin select outside window mode means event counting
	always_comb begin
		if (!counter_control_reg.run) begin
			mode = tmr_pkg::MODE_IDLE;
		end else if (counter_control_reg.window) begin
			mode = tmr_pkg::MODE_WINDOW;
		end else if (counter_control_reg.clk_sel == tmr_pkg::CK_PIN) begin
			mode = tmr_pkg::MODE_EVENT;
		end else begin
			mode = tmr_pkg::MODE_TIMER;
		end
	end

	// internal tick for the chosen source; reserved and pin give none
	always_comb begin
		case (counter_control_reg.clk_sel)
			tmr_pkg::CK_SLOW_DIV:  tick = src_tick[0];
			tmr_pkg::CK_MID_DIV:   tick = src_tick[1];
			tmr_pkg::CK_FAST_DIV:  tick = src_tick[2];
			tmr_pkg::CK_HF_DIV8:   tick = src_tick[3];
			tmr_pkg::CK_HIGH_FREQ: tick = src_tick[4];
			tmr_pkg::CK_LOW_FREQ:  tick = src_tick[5];
			default:               tick = 1'b0;
		endcase
	end

	// fast source in low-speed mode two is warm-up
	assign warmup_mask = (mode == tmr_pkg::MODE_TIMER) && low_speed_mode_two &&
	                     (counter_control_reg.clk_sel == tmr_pkg::CK_HIGH_FREQ);

	// ==========================================================
	// pin synchroniser
	// ==========================================================
	// the filter leans on each pin level lasting two cycles
	pin_sync u_pin_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pin_raw (counter_input_pin),
		.ev      (pin)
	);

	// ==========================================================
	// compare registers
	// ==========================================================
	// one instance checks the count as it stands
	compare_unit u_compare (
		.pclk              (pclk),
		.presetn           (presetn),
		.wr_lo             (wr_lo),
		.wr_hi             (wr_hi),
		.wbyte             (pwdata[7:0]),
		.count_val         (16'(count)),
		.mask_low          (warmup_mask),
		.hit               (hit_now),
		.compare_value_reg (compare_value_reg),
		.pending           (cmp_pending)
	);

	// timer and window match on the post-tick value
	assign count_plus = count + COUNT_W'(1);

	// masked comparison of the incremented count
	always_comb begin
		if (warmup_mask) begin
			hit_next = count_plus[15:tmr_pkg::MASK_LOW_BITS] ==
			           compare_value_reg[15:tmr_pkg::MASK_LOW_BITS];
		end else begin
			hit_next = 16'(count_plus) == compare_value_reg;
		end
	end

	// ==========================================================
	// counter
	// ==========================================================
	// event mode compares on the falling edge, not on the count step,
	// so a rise and fall can never both act in one cycle
	always_comb begin
		next_count = count;
		next_match = 1'b0;
		case (mode)
			tmr_pkg::MODE_IDLE: begin
				next_count = '0;
			end
			tmr_pkg::MODE_TIMER: begin
				if (tick && hit_next) begin
					next_count = '0;
					next_match = 1'b1;
				end else if (tick) begin
					next_count = count_plus;
				end
			end
			tmr_pkg::MODE_EVENT: begin
				if (pin.rise) begin
					next_count = count_plus;
				end else if (pin.fall && hit_now) begin
					next_count = '0;
					next_match = 1'b1;
				end
			end
			tmr_pkg::MODE_WINDOW: begin
				// gate must toggle far slower than the tick; no edge
				// alignment is attempted between the two
				if (tick && pin.level && hit_next) begin
					next_count = '0;
					next_match = 1'b1;
				end else if (tick && pin.level) begin
					next_count = count_plus;
				end
			end
			default: begin
				next_count = '0;
			end
		endcase
	end

	// count state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= COUNT_W'(tmr_pkg::COUNT_RESET);
		end else begin
			count <= next_count;
		end
	end

	// ==========================================================
	// match event
	// ==========================================================
	// registered one-cycle pulse per match
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_interrupt <= 1'b0;
		end else begin
			match_interrupt <= next_match;
		end
	end

	// ==========================================================
	// read data
	// ==========================================================
	// read mux; bits above each register read as zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (addr_hit(paddr, tmr_pkg::IDX_CTRL)) begin
			next_rdata[tmr_pkg::CTRL_RUN_POS]       = counter_control_reg.run;
			next_rdata[tmr_pkg::CTRL_CK_LSB +: 3]   = counter_control_reg.clk_sel;
			next_rdata[tmr_pkg::CTRL_MODE_POS]      = counter_control_reg.window;
		end else if (addr_hit(paddr, tmr_pkg::IDX_CMP_LO)) begin
			next_rdata[7:0] = compare_value_reg[7:0];
		end else if (addr_hit(paddr, tmr_pkg::IDX_CMP_HI)) begin
			next_rdata[7:0] = compare_value_reg[15:8];
		end else if (addr_hit(paddr, tmr_pkg::IDX_COUNT)) begin
			next_rdata[15:0] = 16'(count);
		end else if (addr_hit(paddr, tmr_pkg::IDX_STATUS)) begin
			next_rdata[tmr_pkg::STAT_RUN_POS]  = counter_control_reg.run;
			next_rdata[tmr_pkg::STAT_PEND_POS] = cmp_pending;
			next_rdata[tmr_pkg::STAT_PIN_POS]  = pin.level;
			next_rdata[tmr_pkg::STAT_MASK_POS] = warmup_mask;
		end
	end

	// captured in the setup cycle, stable through the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup_phase && !pwrite) begin
			prdata <= next_rdata;
		end
	end

	// low-speed and sleep restrictions on window mode are left to
	// software; the block does not police them

endmodule : event_window_counter

`default_nettype wire

// ---- bench/ewc_checker.sv ----
// checker: bus, run bit, compare pairing and pin timing
// sees only the counter's ports; bound at the foot
`timescale 1ns/10ps
`default_nettype none

module ewc_checker #(
	parameter int unsigned COUNT_W = 16
) (
	// clock and reset
	input wire logic                       pclk,
	input wire logic                       presetn,
	// apb
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [tmr_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0]                pwdata,
	input wire logic [31:0]                prdata,
	input wire logic                       pready,
	input wire logic                       pslverr,
	// sources, power and pin
	input wire logic [5:0]                 src_tick,
	input wire logic                       low_speed_mode_two,
	input wire logic                       stop_mode_entry,
	input wire logic                       counter_input_pin,
	input wire logic                       match_interrupt
);
	// ==========================================================
	// shadow state
	// ==========================================================
	localparam logic [7:0] A_CTRL = {tmr_pkg::IDX_CTRL, 2'b00};
	localparam logic [7:0] A_LO   = {tmr_pkg::IDX_CMP_LO, 2'b00};
	localparam logic [7:0] A_HI   = {tmr_pkg::IDX_CMP_HI, 2'b00};
	localparam logic [7:0] A_CNT  = {tmr_pkg::IDX_COUNT, 2'b00};
	localparam logic [7:0] A_STAT = {tmr_pkg::IDX_STATUS, 2'b00};
	logic        wr, rd, mapped, run_sh, win_sh, ev_sh, staged, pin_q;
	logic [2:0]  sel_sh;
	logic [7:0]  lo_sh;
	logic [15:0] cmp_sh;
	logic [3:0]  low_cnt, fall_cnt;

	assign wr = psel & penable & pwrite & pready;
	assign rd = psel & ~penable & ~pwrite;
	assign mapped = paddr inside {A_CTRL, A_LO, A_HI, A_CNT, A_STAT};
	assign ev_sh = run_sh & (sel_sh == 3'h7) & ~win_sh;

	// control shadow; stop entry beats a write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_sh <= 1'b0;
			sel_sh <= 3'h0;
			win_sh <= 1'b0;
		end else if (stop_mode_entry) begin
			run_sh <= 1'b0;
		end else if (wr && paddr == A_CTRL) begin
			run_sh <= pwdata[tmr_pkg::CTRL_RUN_POS];
			sel_sh <= pwdata[4:2];
			win_sh <= pwdata[tmr_pkg::CTRL_MODE_POS];
		end
	end

	// compare shadow: high write after low commits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_sh <= tmr_pkg::CMP_RESET;
			lo_sh  <= tmr_pkg::BYTE_RESET;
			staged <= 1'b0;
		end else if (wr && paddr == A_LO) begin
			lo_sh  <= pwdata[7:0];
			staged <= 1'b1;
		end else if (wr && paddr == A_HI && staged) begin
			cmp_sh <= {pwdata[7:0], lo_sh};
			staged <= 1'b0;
		end
	end

	// saturating ages of pin low and last fall
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_q    <= 1'b0;
			low_cnt  <= 4'h0;
			fall_cnt <= 4'hF;
		end else begin
			pin_q    <= counter_input_pin;
			low_cnt  <= counter_input_pin ? 4'h0 : low_cnt + {3'h0, low_cnt != 4'hF};
			fall_cnt <= (pin_q && !counter_input_pin) ? 4'h0 : fall_cnt + {3'h0, fall_cnt != 4'hF};
		end
	end

	// ==========================================================
	// properties
	// ==========================================================
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// three idle cycles drain a pulse in flight
	sequence s_idle;
		!run_sh [*3];
	endsequence
	sequence s_idle_cnt_rd;
		!run_sh [*2] ##0 (rd && paddr == A_CNT);
	endsequence

	a_irq_pulse: assert property (match_interrupt |=> !match_interrupt)
		else $error("match pulse too long");
	a_run_off_quiet: assert property (s_idle |-> !match_interrupt)
		else $error("match pulse while stopped");
	a_run_readback: assert property (rd && paddr == A_STAT |=> prdata[0] == $past(run_sh))
		else $error("run readback differs");
	a_cmp_lo_read: assert property (rd && paddr == A_LO |=> prdata[7:0] == $past(cmp_sh[7:0]))
		else $error("compare low differs");
	a_cmp_hi_read: assert property (rd && paddr == A_HI |=> prdata[7:0] == $past(cmp_sh[15:8]))
		else $error("compare high differs");
	a_count_idle: assert property (s_idle_cnt_rd |=> prdata[15:0] == 16'h0000)
		else $error("count not zero while stopped");
	a_event_on_fall: assert property (match_interrupt && ev_sh |-> fall_cnt inside {[2:9]})
		else $error("event match off pin fall");
	a_window_gate: assert property (win_sh && low_cnt == 4'hF |-> !match_interrupt)
		else $error("window match with gate low");
	a_bus_answer: assert property (psel && penable |-> pready && (pslverr == !mapped))
		else $error("bus answer wrong");
endmodule : ewc_checker

bind event_window_counter ewc_checker #(.COUNT_W(COUNT_W)) i_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.src_tick(src_tick), .low_speed_mode_two(low_speed_mode_two),
	.stop_mode_entry(stop_mode_entry), .counter_input_pin(counter_input_pin),
	.match_interrupt(match_interrupt));
`default_nettype wire

// ---- bench/pin_source.sv ----
// pulse and gate source driving the counter input pin
// assumes a one-cycle start from the bench
`timescale 1ns/10ps
`default_nettype none

module pin_source (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// request
	input  wire logic       start,
	input  wire logic [7:0] npulse,
	input  wire logic [7:0] width,
	input  wire logic       gate,
	// pin and state
	output logic            pin,
	output logic            busy
);
	logic [8:0] phases;
	logic [7:0] left;
	logic [7:0] w;
	logic       level;

	// short levels stretched so the filter sees them
	assign w = (width < 8'h04) ? 8'h04 : width;
	assign busy = (phases != 9'h000);
	// gate: slow level held by the bench
	assign pin = level | gate;

	// alternating phases of w cycles, ending low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phases <= 9'h000;
			left   <= 8'h00;
			level  <= 1'b0;
		end else if (start && npulse != 8'h00) begin
			phases <= {npulse, 1'b0};
			left   <= w - 8'h01;
			level  <= 1'b1;
		end else if (busy) begin
			if (left == 8'h00) begin
				phases <= phases - 9'h001;
				left   <= w - 8'h01;
				level  <= (phases > 9'h001) ? ~level : 1'b0;
			end else begin
				left <= left - 8'h01;
			end
		end
	end
endmodule : pin_source
`default_nettype wire

// ---- bench/test_timer_event_window_counter16.sv ----
// bench: period table, then pairing, events, warm-up, stop, bus error, reset
// assumes the bound checker and pin_source
`timescale 1ns/10ps
`default_nettype none

module test_timer_event_window_counter16;
	// ==========================================================
	// signals
	// ==========================================================
	localparam logic [7:0] A_CTRL = {tmr_pkg::IDX_CTRL, 2'b00};
	localparam logic [7:0] A_LO   = {tmr_pkg::IDX_CMP_LO, 2'b00};
	localparam logic [7:0] A_HI   = {tmr_pkg::IDX_CMP_HI, 2'b00};
	localparam logic [7:0] A_CNT  = {tmr_pkg::IDX_COUNT, 2'b00};
	localparam logic [7:0] A_STAT = {tmr_pkg::IDX_STATUS, 2'b00};
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, lsm2 = 1'b0, stop = 1'b0, start = 1'b0;
	logic        gate = 1'b0, fast = 1'b0, pready, pslverr, match_interrupt, pin, busy, e;
	logic [7:0]  paddr = 8'h00, npulse = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [5:0]  src_tick = 6'h00;
	int          cyc = 0, irq_n = 0, err_count = 0, num_checks = 0, p, base;
	typedef struct {logic [7:0] ctrl; logic [15:0] cmp; logic gate; int exp;} row_s;
	// tick bit n fires every n+1 cycles
	row_s rows [9] = '{'{8'h20, 16'h0003, 1'b0, 3}, '{8'h24, 16'h0005, 1'b0, 10},
		'{8'h28, 16'h0002, 1'b0, 6}, '{8'h2C, 16'h0004, 1'b0, 16}, '{8'h30, 16'h0003, 1'b0, 15},
		'{8'h34, 16'h0002, 1'b0, 12}, '{8'h38, 16'h0002, 1'b0, 0},
		'{8'h21, 16'h0004, 1'b1, 4}, '{8'h25, 16'h0002, 1'b0, 0}};
	int ev_n [3] = '{3, 2, 1};
	int ev_x [3] = '{1, 1, 2};
	logic [7:0]  rst_a [5] = '{A_CTRL, A_LO, A_HI, A_CNT, A_STAT};
	logic [31:0] rst_v [5] = '{32'h0, 32'hFF, 32'hFF, 32'h0, 32'h0};

	event_window_counter #(.COUNT_W(16)) i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.src_tick(src_tick), .low_speed_mode_two(lsm2), .stop_mode_entry(stop),
		.counter_input_pin(pin), .match_interrupt(match_interrupt));
	pin_source i_src (.pclk(pclk), .presetn(presetn), .start(start), .npulse(npulse),
		.width(8'h0A), .gate(gate), .pin(pin), .busy(busy));

	// ==========================================================
	// clock, ticks and pulse count
	// ==========================================================
	always #12.5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		for (int n = 0; n < 6; n++) begin
			src_tick[n] <= fast || (cyc % (n + 1) == 0);
		end
		if (match_interrupt === 1'b1) begin
			irq_n <= irq_n + 1;
		end
	end

	// ==========================================================
	// tasks
	// ==========================================================
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		num_checks++;
		if (g !== x) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, x, g);
			err_count++;
		end
	endtask : chk

	// halt before changing mode or source
	task automatic setup(input logic [7:0] c, input logic [15:0] v);
		apb(1'b1, A_CTRL, 32'h0);
		apb(1'b1, A_LO, {24'h0, v[7:0]});
		apb(1'b1, A_HI, {24'h0, v[15:8]});
		apb(1'b1, A_CTRL, {24'h0, c & 8'hDF});
		apb(1'b1, A_CTRL, {24'h0, c});
	endtask : setup

	// skip to a pulse, then time the next; 0 if none
	task automatic per(input int lim);
		int c0, i0;
		p = 0;
		repeat (2) begin
			c0 = cyc;
			i0 = irq_n;
			while (irq_n == i0 && cyc - c0 < lim) @(negedge pclk);
		end
		if (irq_n != i0) p = cyc - c0;
	endtask : per

	task automatic pulses(input logic [7:0] n);
		int k = 0;
		@(posedge pclk);
		npulse <= n;
		start <= 1'b1;
		@(posedge pclk);
		start <= 1'b0;
		@(negedge pclk);
		while (busy !== 1'b0 && k < 500) begin
			@(negedge pclk);
			k++;
		end
		repeat (10) @(negedge pclk);
	endtask : pulses

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results

	// ==========================================================
	// tests
	// ==========================================================
	initial begin
		#(25 * 40000);
		err_count++;
		results();
	end

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			gate <= rows[i].gate;
			setup(rows[i].ctrl, rows[i].cmp);
			per(400);
			chk("period", rows[i].exp, p);
			$display("row %0d done", i);
		end
		// lone byte writes leave the compare alone
		apb(1'b1, A_CTRL, 32'h0);
		apb(1'b1, A_HI, 32'h12);
		apb(1'b0, A_HI, 32'h0);
		chk("cmp_hi", 32'h0, q);
		apb(1'b1, A_LO, 32'h34);
		apb(1'b0, A_LO, 32'h0);
		chk("cmp_lo", 32'h02, q);
		apb(1'b1, A_HI, 32'h12);
		apb(1'b0, A_LO, 32'h0);
		chk("cmp_lo", 32'h34, q);
		apb(1'b0, A_HI, 32'h0);
		chk("cmp_hi", 32'h12, q);
		$display("pairing done");
		setup(8'h3C, 16'h0003);
		base = irq_n;
		foreach (ev_n[k]) begin
			pulses(8'(ev_n[k]));
			chk("events", ev_x[k], 32'(irq_n - base));
		end
		$display("event done");
		fast <= 1'b1;
		lsm2 <= 1'b1;
		setup(8'h30, 16'h0FFF);
		per(5000);
		chk("warmup", 32'h0000_0800, p);
		apb(1'b0, A_STAT, 32'h0);
		chk("run", 32'h1, {31'h0, q[tmr_pkg::STAT_RUN_POS]});
		// stop entry drops run bit and empties the counter
		lsm2 <= 1'b0;
		stop <= 1'b1;
		@(posedge pclk);
		stop <= 1'b0;
		apb(1'b0, A_STAT, 32'h0);
		chk("run", 32'h0, {31'h0, q[tmr_pkg::STAT_RUN_POS]});
		apb(1'b0, A_CNT, 32'h0);
		chk("count", 32'h0, q);
		per(300);
		chk("stopped", 32'h0, p);
		$display("warm-up and stop done");
		apb(1'b1, 8'h00, 32'hFF);
		chk("err", 32'h1, {31'h0, e});
		apb(1'b0, 8'h00, 32'h0);
		chk("err", 32'h1, {31'h0, e});
		chk("data", 32'h0, q);
		// mid-run reset restores reset values
		setup(8'h20, 16'h0005);
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rst_a[k]) begin
			apb(1'b0, rst_a[k], 32'h0);
			chk("reset", rst_v[k], q);
		end
		$display("bus and reset done");
		results();
	end
endmodule : test_timer_event_window_counter16
`default_nettype wire
